// ---- bench/sdw_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdw_host import sdw_pkg::*; (
	// Clock and answer
	input wire logic i_clk,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	input wire logic i_pslverr,
	// Request
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata
);
	logic [31:0] last_rd;
	logic last_err;
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
	end
	// One transfer; released lines show inverted junk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		@(posedge i_clk);
		while (i_pready !== 1'b1) @(posedge i_clk);
		last_rd = i_prdata;
		last_err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_paddr <= ~a;
		o_pwdata <= ~d;
	endtask
	// Load the block bytes little-endian, start, poll done
	task automatic cmd(input logic [31:0] ctl, c0, c1, c2);
		xfer(1'b1, OFS_CDB0, c0);
		xfer(1'b1, OFS_CDB1, c1);
		xfer(1'b1, OFS_CDB2, c2);
		xfer(1'b1, OFS_CTRL, ctl);
		last_rd = 32'h0;
		while (last_rd[1] !== 1'b1) xfer(1'b0, OFS_STAT, 32'h0);
	endtask
endmodule
`default_nettype wire

// ---- bench/sdw_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdw_top_asserts #(
	parameter int ST_CYC = 4
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_busy,
	input wire logic o_default_check_flag_run,
	input wire logic o_diag_start,
	input wire logic o_ucode_load,
	input wire logic o_ucode_save
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	int st_cnt;
	// Length of the running self-test
	always_ff @(posedge i_clk) begin
		if (i_rst || !o_default_check_flag_run) begin
			st_cnt <= 0;
		end else begin
			st_cnt <= st_cnt + 1;
		end
	end
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable;
	endsequence
	apb_wait_a: assert property (s_setup ##1 s_access |-> !o_pready ##1 o_pready)
		else $error("ready not after one wait state");
	rdy_pulse_a: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	err_rdy_a: assert property (o_pslverr |-> o_pready && i_psel && i_penable)
		else $error("error outside answer");
	save_load_a: assert property (o_ucode_save |-> o_ucode_load)
		else $error("save without load");
	load_pulse_a: assert property (o_ucode_load |=> !o_ucode_load)
		else $error("load pulse too long");
	diag_pulse_a: assert property (o_diag_start |=> !o_diag_start)
		else $error("diag start too long");
	st_quiet_a: assert property (o_default_check_flag_run |-> o_busy && !o_diag_start)
		else $error("self-test outside command");
	st_len_a: assert property ($fell(o_default_check_flag_run) |-> st_cnt == ST_CYC)
		else $error("self-test length wrong");
	cmd_done_a: assert property ($rose(o_busy) |-> o_busy ##[2:300] !o_busy)
		else $error("command never ends");
endmodule
bind sdw_top sdw_top_asserts #(.ST_CYC(ST_CYC)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_busy(o_busy), .o_default_check_flag_run(o_default_check_flag_run), .o_diag_start(o_diag_start),
	.o_ucode_load(o_ucode_load), .o_ucode_save(o_ucode_save));
`default_nettype wire

// ---- bench/test_scsi_diag_tur_wrbuf_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_scsi_diag_tur_wrbuf_decode import sdw_pkg::*;;
	localparam logic [31:0] GO = 32'h21;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic ce = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, busy, st_run, dstart;
	logic mgr, tgr, mlock, uload, usave;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int error_cnt = 0;
	int n_tests = 0;
	int n_diag = 0, n_load = 0, n_save = 0, n_st = 0;
	always #5 i_clk = ~i_clk;
	sdw_top #(.ST_CYC(4)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_busy(busy),
		.o_default_check_flag_run(st_run), .o_diag_start(dstart), .o_medium_offline_grant(mgr),
		.o_whole_target_offline_grant(tgr), .o_medium_lock(mlock), .o_ucode_load(uload),
		.o_ucode_save(usave));
	sdw_host u_host (.i_clk(i_clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
	// Count pulses and self-test cycles
	always @(posedge i_clk) begin
		n_diag <= n_diag + int'(dstart === 1'b1);
		n_load <= n_load + int'(uload === 1'b1);
		n_save <= n_save + int'(usave === 1'b1);
		n_st <= n_st + int'(st_run === 1'b1);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0);
		chk(u_host.last_rd, exp);
	endtask
	// Run a command, then compare status, sense key and code
	task automatic run(input logic [31:0] ctl, c0, c1, c2, input logic [7:0] st,
		input logic [3:0] key, input logic [7:0] asc);
		u_host.cmd(ctl, c0, c1, c2);
		u_host.xfer(1'b0, OFS_STAT, 32'h0);
		chk({24'h0, u_host.last_rd[15:8]}, {24'h0, st});
		u_host.xfer(1'b0, OFS_SENSE, 32'h0);
		chk({20'h0, u_host.last_rd[19:8]}, {20'h0, key, asc});
	endtask
	initial begin
		#200000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		chk({24'h0, busy, st_run, dstart, mgr, tgr, mlock, uload, usave}, 32'h0);
		rd(OFS_CTRL, CTRL_RST);
		rd(OFS_VSENSE, VSENSE_RST);
		u_host.xfer(1'b0, 8'h28, 32'h0);
		chk({31'h0, u_host.last_err}, 32'h1);
		run(GO, 32'h0, 32'h0, 32'h0, ST_GOOD, SK_NONE, ASC_NONE);
		run(GO | 32'h4, 32'h0, 32'h0, 32'h0, ST_BUSYS, SK_NONE, ASC_NONE);
		run(GO | 32'h8, 32'h0, 32'h0, 32'h0, ST_RESV, SK_NONE, ASC_NONE);
		run(GO, 32'h2000, 32'h0, 32'h0, ST_CHECK, SK_ILL, ASC_NOLUN);
		for (int c = 1; c < 6; c++) begin
			run(GO | (c << 8), 32'h0, 32'h0, 32'h0, ST_CHECK, SK_NRDY,
				(c == 1) ? ASC_NOMED : ASC_NRDY);
		end
		chk(n_st, 0);
		run(GO, 32'h041D, 32'h0, 32'h0, ST_GOOD, SK_NONE, ASC_NONE);
		chk(n_st, 4);
		u_host.xfer(1'b1, OFS_VSENSE, 32'h9033);
		run(GO | 32'h10, 32'h041D, 32'h0, 32'h0, ST_CHECK, SK_HW, 8'h90);
		u_host.xfer(1'b1, OFS_VSENSE, 32'h7F00);
		run(GO | 32'h10, 32'h041D, 32'h0, 32'h0, ST_CHECK, SK_HW, ASC_NONE);
		run(GO, 32'h0100031D, 32'h2, 32'h0, ST_GOOD, SK_NONE, ASC_NONE);
		chk(n_diag, 1);
		chk({30'h0, mgr, tgr}, 32'h3);
		ce <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk({28'h0, busy, pready, mgr, tgr}, 32'h3);
		ce <= 1'b1;
		rd(OFS_LEN, 32'h102);
		u_host.xfer(1'b0, OFS_DEC, 32'h0);
		chk({28'h0, u_host.last_rd[6:3]}, 32'hC);
		run(GO | 32'h2, 32'h011D, 32'h0, 32'h0, ST_GOOD, SK_NONE, ASC_NONE);
		chk({n_diag[29:0], mgr, tgr}, 32'h6);
		u_host.xfer(1'b1, OFS_PAGE, 32'h8);
		run(GO, 32'h101D, 32'h4, 32'h0, ST_CHECK, SK_ILL, ASC_BADCDB);
		run(GO, 32'h101D, 32'h8, 32'h0, ST_GOOD, SK_NONE, ASC_NONE);
		for (int m = 0; m < 8; m++) begin
			run(GO, {16'h0, 5'h0, m[2:0], 8'h3B}, 32'h0, 32'h10,
				(m inside {3, 6, 7}) ? ST_CHECK : ST_GOOD,
				(m inside {3, 6, 7}) ? SK_ILL : SK_NONE,
				(m inside {3, 6, 7}) ? ASC_BADCDB : ASC_NONE);
			chk({31'h0, mlock}, {31'h0, m == 0 || m == 2});
		end
		chk({n_load[15:0], n_save[15:0]}, 32'h20001);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(OFS_PAGE, 32'h0);
		rd(OFS_CTRL, CTRL_RST);
		run(GO, 32'hFF, 32'h0, 32'h0, ST_CHECK, SK_ILL, ASC_BADOP);
		close_out();
	end
endmodule
`default_nettype wire

// ---- pkg/sdw_pkg.sv ----
package sdw_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CDB0 = 8'h04;
	localparam logic [7:0] OFS_CDB1 = 8'h08;
	localparam logic [7:0] OFS_CDB2 = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_SENSE = 8'h14;
	localparam logic [7:0] OFS_DEC = 8'h18;
	localparam logic [7:0] OFS_LEN = 8'h1C;
	localparam logic [7:0] OFS_PAGE = 8'h20;
	localparam logic [7:0] OFS_VSENSE = 8'h24;
	// Control field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_DEFER = 1;
	localparam int CTRL_BUSY = 2;
	localparam int CTRL_RESV = 3;
	localparam int CTRL_STFAIL = 4;
	localparam int CTRL_PFSUP = 5;
	localparam int CTRL_CAUSE = 8;
	localparam int CTRL_LUNMAX = 12;
	localparam logic [31:0] CTRL_RST = 32'h0000_0020;
	localparam logic [31:0] VSENSE_RST = 32'h0000_8000;
	// Operation codes
	localparam logic [7:0] OP_DIAG = 8'h1D;
	localparam logic [7:0] OP_READY = 8'h00;
	localparam logic [7:0] OP_WRBUF = 8'h3B;
	// Diagnostic byte 1 bit positions
	localparam int B1_PF = 4;
	localparam int B1_ST = 2;
	localparam int B1_DEV = 1;
	localparam int B1_UNIT = 0;
	// Status bytes
	localparam logic [7:0] ST_GOOD = 8'h00;
	localparam logic [7:0] ST_CHECK = 8'h02;
	localparam logic [7:0] ST_BUSYS = 8'h08;
	localparam logic [7:0] ST_RESV = 8'h18;
	// Sense keys
	localparam logic [3:0] SK_NONE = 4'h0;
	localparam logic [3:0] SK_NRDY = 4'h2;
	localparam logic [3:0] SK_HW = 4'h4;
	localparam logic [3:0] SK_ILL = 4'h5;
	// Additional sense codes
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_NRDY = 8'h04;
	localparam logic [7:0] ASC_BADOP = 8'h20;
	localparam logic [7:0] ASC_BADCDB = 8'h24;
	localparam logic [7:0] ASC_NOLUN = 8'h25;
	localparam logic [7:0] ASC_NOMED = 8'h3A;
	localparam logic [7:0] ASC_VEND = 8'h80;
	// Write buffer modes
	localparam logic [2:0] WM_HDR = 3'h0;
	localparam logic [2:0] WM_VEND = 3'h1;
	localparam logic [2:0] WM_DATA = 3'h2;
	localparam logic [2:0] WM_UC = 3'h4;
	localparam logic [2:0] WM_UCSAVE = 3'h5;
	localparam logic [23:0] WB_HDR_LEN = 24'h000004;
	// Self-test duration
	localparam int DEFAULT_CHECK_FLAG_NS = 2000;
	localparam int CLK_NS = 10;
	localparam int DEFAULT_CHECK_FLAG_CYC = (DEFAULT_CHECK_FLAG_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {S_IDLE, S_DEC, S_TEST, S_END} sdw_state_t;
endpackage

// ---- verilog/sdw_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdw_top import sdw_pkg::*; #(
	parameter int BUF_COUNT = 1,
	parameter logic [23:0] BUF_CAP = 24'h001000,
	parameter int ST_CYC = DEFAULT_CHECK_FLAG_CYC
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Command outcome and grants
	output logic o_busy,
	output logic o_default_check_flag_run,
	output logic o_diag_start,
	output logic o_medium_offline_grant,
	output logic o_whole_target_offline_grant,
	output logic o_medium_lock,
	output logic o_ucode_load,
	output logic o_ucode_save
);
	// Keep only vendor codes or codes this block assigns
	function automatic logic [15:0] legal_sense(input logic [7:0] asc, input logic [7:0] ascq);
		logic ok;
		ok = 1'b0;
		// Either byte in the upper half is a vendor code or refinement
		if (asc >= ASC_VEND || ascq >= ASC_VEND) ok = 1'b1;
		// No additional sense information
		if (asc == ASC_NONE && ascq == 8'h00) ok = 1'b1;
		// Not-ready family, causes 0 to 4
		if (asc == ASC_NRDY && ascq <= 8'h04) ok = 1'b1;
		// Invalid opcode, invalid field, unsupported unit
		if ((asc == ASC_BADOP || asc == ASC_BADCDB || asc == ASC_NOLUN) && ascq == 8'h00) ok = 1'b1;
		// Medium not present
		if (asc == ASC_NOMED && ascq == 8'h00) ok = 1'b1;
		// Anything else is reserved and reported as no sense
		legal_sense = ok ? {asc, ascq} : 16'h0000;
	endfunction

	// Buffer write modes that must leave every medium untouched
	function automatic logic keeps_media(input logic [2:0] m);
		keeps_media = m == WM_HDR || m == WM_DATA;
	endfunction

	// Microcode transfer modes, with and without saving
	function automatic logic is_ucode(input logic [2:0] m);
		is_ucode = m == WM_UC || m == WM_UCSAVE;
	endfunction

	// Reserved buffer write modes, always refused
	function automatic logic is_rsvd_mode(input logic [2:0] m);
		is_rsvd_mode = m == 3'h3 || m == 3'h6 || m == 3'h7;
	endfunction

	// Software registers
	logic [31:0] ctrl;
	logic [31:0] cdb0;
	logic [31:0] cdb1;
	logic [31:0] cdb2;
	logic [15:0] page_need;
	logic [15:0] vsense;

	// Command results
	logic done;
	logic [7:0] status;
	logic [3:0] skey;
	logic [15:0] sense;

	// Latched length, self-test count and sequencer state
	logic [23:0] len_lat;
	logic [15:0] st_cnt;
	sdw_state_t state;

	// Command block fields
	wire [7:0] op = cdb0[7:0];
	wire [7:0] b1 = cdb0[15:8];
	wire [2:0] lun = b1[7:5];
	wire pf = b1[B1_PF];
	wire st = b1[B1_ST];
	wire dev_ok = b1[B1_DEV];
	wire unit_ok = b1[B1_UNIT];
	wire [15:0] diag_len = {cdb0[31:24], cdb1[7:0]};
	wire [2:0] wmode = b1[2:0];
	wire [7:0] buf_id = cdb0[23:16];
	wire [23:0] buf_ofs = {cdb0[31:24], cdb1[7:0], cdb1[15:8]};
	wire [23:0] wb_len = {cdb1[23:16], cdb1[31:24], cdb2[7:0]};
	wire [2:0] cause = ctrl[CTRL_CAUSE +: 3];
	wire [2:0] lun_max = ctrl[CTRL_LUNMAX +: 3];
	wire [24:0] wb_end = {1'b0, buf_ofs} + {1'b0, wb_len};
	wire len_zero = diag_len == 16'h0000;

	// Which command the block holds
	wire is_tur = op == OP_READY;
	wire is_diag = op == OP_DIAG;
	wire is_wrbuf = op == OP_WRBUF;

	// Software control bits
	wire defer_run = ctrl[CTRL_DEFER];
	wire force_busy = ctrl[CTRL_BUSY];
	wire force_resv = ctrl[CTRL_RESV];
	wire st_fails = ctrl[CTRL_STFAIL];
	wire pf_supported = ctrl[CTRL_PFSUP];

	// APB decode
	wire acc = i_psel & i_penable & o_pready;
	wire wr = acc & i_pwrite & i_ce;
	wire hit = i_paddr[1:0] == 2'b00 && i_paddr <= OFS_VSENSE;
	wire go = wr && i_paddr == OFS_CTRL && i_pwdata[CTRL_GO] && state == S_IDLE;
	// Register writes only land while no command runs
	wire reg_wr = wr && hit && state == S_IDLE;

	// Diagnostic request outcome
	// A zero length has no pages to cut, so it never trips the check
	wire pf_trunc = pf && !len_zero && diag_len < page_need;
	wire pf_bad = pf && !pf_supported;

	// Buffer write checks
	wire wm_rsvd = is_rsvd_mode(wmode);
	// Header mode: buffer zero, offset zero, length within header plus capacity
	wire hdr_id_bad = buf_id != 8'h00;
	wire hdr_ofs_bad = buf_ofs != 24'h000000;
	wire [24:0] hdr_room = {1'b0, BUF_CAP} + {1'b0, WB_HDR_LEN};
	wire hdr_len_bad = {1'b0, wb_len} > hdr_room;
	wire hdr_bad = wmode == WM_HDR && (hdr_id_bad || hdr_ofs_bad || hdr_len_bad);
	// Data mode: the buffer must exist and the transfer must fit in it
	wire data_id_bad = {24'h000000, buf_id} >= 32'(BUF_COUNT);
	wire data_fit_bad = wb_end > {1'b0, BUF_CAP};
	wire data_bad = wmode == WM_DATA && (data_id_bad || data_fit_bad);
	wire wb_bad = wm_rsvd || hdr_bad || data_bad;

	// Command outcome: status, sense key, sense and self-test request
	logic [7:0] next_status;
	logic [3:0] next_skey;
	logic [15:0] next_sense;
	logic next_test;
	always_comb begin
		next_status = ST_GOOD;
		next_skey = SK_NONE;
		next_sense = 16'h0000;
		next_test = 1'b0;
		// Forced busy, then reservation, then unit number
		if (force_busy) begin
			next_status = ST_BUSYS;
		end else if (force_resv) begin
			next_status = ST_RESV;
		end else if (lun > lun_max) begin
			// Unit beyond the highest one present
			next_status = ST_CHECK;
			next_skey = SK_ILL;
			next_sense = {ASC_NOLUN, 8'h00};
		end else if (is_tur) begin
			// Readiness query never starts the self-test
			if (cause != 3'h0) begin
				next_status = ST_CHECK;
				next_skey = SK_NRDY;
				unique case (cause)
					3'h1: next_sense = {ASC_NOMED, 8'h00};
					3'h2: next_sense = {ASC_NRDY, 8'h01};
					3'h3: next_sense = {ASC_NRDY, 8'h02};
					3'h4: next_sense = {ASC_NRDY, 8'h03};
					3'h5: next_sense = {ASC_NRDY, 8'h04};
					default: next_sense = {ASC_NRDY, 8'h00};
				endcase
			end
		end else if (is_diag) begin
			if (st) begin
				// Self-test runs in its own state
				next_test = 1'b1;
			end else if (pf_trunc || pf_bad) begin
				// Pages cut by the length, or pages not supported
				next_status = ST_CHECK;
				next_skey = SK_ILL;
				next_sense = {ASC_BADCDB, 8'h00};
			end
		end else if (is_wrbuf) begin
			if (wb_bad) begin
				next_status = ST_CHECK;
				next_skey = SK_ILL;
				next_sense = {ASC_BADCDB, 8'h00};
			end
		end else begin
			// Unknown operation code
			next_status = ST_CHECK;
			next_skey = SK_ILL;
			next_sense = {ASC_BADOP, 8'h00};
		end
	end

	// Accepted commands that cause work outside the block
	wire diag_go = is_diag && !st && next_status == ST_GOOD;
	wire wb_go = is_wrbuf && next_status == ST_GOOD;
	wire test_end = state == S_TEST && st_cnt == 16'(ST_CYC - 1);

	// Next values of the side-effect outputs
	wire next_busy = (state == S_IDLE && go) || (state != S_IDLE && state != S_END);
	wire next_default_check_flag_run = (state == S_DEC && next_test) || (state == S_TEST && !test_end);
	// Immediate run, unless software asked to defer to the fetch
	wire next_diag_start = state == S_DEC && diag_go && !defer_run;
	wire next_ucode_load = state == S_DEC && wb_go && is_ucode(wmode);
	wire next_ucode_save = state == S_DEC && wb_go && wmode == WM_UCSAVE;
	// Grants follow the last diagnostic request only
	wire grant_upd = state == S_DEC && is_diag;
	// Lock taken at decode, dropped when the next command starts
	wire lock_set = state == S_DEC;
	wire lock_clr = state == S_IDLE && go;
	wire next_lock = is_wrbuf && keeps_media(wmode);

	// Status and decoded-field words
	wire [31:0] stat_word = {16'h0000, status, 6'h00, done, o_busy};
	wire [31:0] dec_word = {21'h0, lun, 1'b0, unit_ok, dev_ok, st, pf, wmode};

	// Read mux, the go bit always reads zero
	logic [31:0] rd;
	always_comb begin
		unique case (i_paddr)
			OFS_CTRL: rd = {ctrl[31:1], 1'b0};
			OFS_CDB0: rd = cdb0;
			OFS_CDB1: rd = cdb1;
			OFS_CDB2: rd = {16'h0000, cdb2[15:0]};
			OFS_STAT: rd = stat_word;
			OFS_SENSE: rd = {12'h000, skey, sense};
			OFS_DEC: rd = dec_word;
			OFS_LEN: rd = {8'h00, len_lat};
			OFS_PAGE: rd = {16'h0000, page_need};
			OFS_VSENSE: rd = {16'h0000, vsense};
			default: rd = 32'h0000_0000;
		endcase
	end

	// APB handshake, one wait state
	// Ready is armed by the first access edge and answered at the next;
	// the ~o_pready term keeps a held access from seeing a second pulse
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (i_ce) begin
			o_pready <= i_psel & i_penable & ~o_pready;
			o_prdata <= rd;
			o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
		end
	end

	// Software registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl <= CTRL_RST;
			cdb0 <= 32'h0000_0000;
			cdb1 <= 32'h0000_0000;
			cdb2 <= 32'h0000_0000;
			page_need <= 16'h0000;
			vsense <= VSENSE_RST[15:0];
		end else if (reg_wr) begin
			unique case (i_paddr)
				OFS_CTRL: ctrl <= {i_pwdata[31:1], 1'b0};
				OFS_CDB0: cdb0 <= i_pwdata;
				OFS_CDB1: cdb1 <= i_pwdata;
				OFS_CDB2: cdb2 <= i_pwdata;
				OFS_PAGE: page_need <= i_pwdata[15:0];
				OFS_VSENSE: vsense <= i_pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Command sequencer
	// Idle waits for go, decode latches the outcome, the self-test state
	// counts its cycles, and the end state raises done until the next go
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= S_IDLE;
			st_cnt <= 16'h0000;
			done <= 1'b0;
			status <= ST_GOOD;
			skey <= SK_NONE;
			sense <= 16'h0000;
			len_lat <= 24'h000000;
		end else if (i_ce) begin
			unique case (state)
				S_IDLE: if (go) begin
					state <= S_DEC;
					done <= 1'b0;
				end
				S_DEC: begin
					// Results stand until the next command decodes
					len_lat <= is_wrbuf ? wb_len : {8'h00, diag_len};
					status <= next_status;
					skey <= next_skey;
					sense <= legal_sense(next_sense[15:8], next_sense[7:0]);
					st_cnt <= 16'h0000;
					state <= next_test ? S_TEST : S_END;
				end
				S_TEST: begin
					// Count to the self-test length, then judge pass or fail
					st_cnt <= st_cnt + 16'h0001;
					if (test_end) begin
						state <= S_END;
						if (st_fails) begin
							status <= ST_CHECK;
							skey <= SK_HW;
							sense <= legal_sense(vsense[15:8], vsense[7:0]);
						end
					end
				end
				S_END: begin
					state <= S_IDLE;
					done <= 1'b1;
				end
			endcase
		end
	end

	// Side-effect outputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_busy <= 1'b0;
			o_default_check_flag_run <= 1'b0;
			o_diag_start <= 1'b0;
			o_medium_offline_grant <= 1'b0;
			o_whole_target_offline_grant <= 1'b0;
			o_medium_lock <= 1'b0;
			o_ucode_load <= 1'b0;
			o_ucode_save <= 1'b0;
		end else if (i_ce) begin
			o_busy <= next_busy;
			o_default_check_flag_run <= next_default_check_flag_run;
			o_diag_start <= next_diag_start;
			if (grant_upd) begin
				o_medium_offline_grant <= unit_ok;
				o_whole_target_offline_grant <= dev_ok;
			end
			if (lock_set) begin
				o_medium_lock <= next_lock;
			end else if (lock_clr) begin
				o_medium_lock <= 1'b0;
			end
			o_ucode_load <= next_ucode_load;
			o_ucode_save <= next_ucode_save;
		end
	end
endmodule
`default_nettype wire
